/* File: qbus_host.sv */
// host bus master for a four-channel uart parallel register port
// assumes device pins are sampled synchronously; data bus split into in/out/oe
`default_nettype none
module qbus_host
    import qbus_pkg::*;
(
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_N_I,
    input  wire logic       STYLE_I,
    input  wire logic       REQ_VALID_I,
    output logic            REQ_READY_O,
    input  wire req_t       REQ_I,
    output logic            RSP_VALID_O,
    output logic [7:0]      RSP_DATA_O,
    output logic            MODE_SELECT_O,
    output logic            READ_STROBE_N_O,
    output logic            WRITE_STROBE_N_O,
    output logic            CHAN_FIRST_SELECT_N_O,
    output logic            CHAN_SECOND_SELECT_N_O,
    output logic            CHAN_THIRD_SELECT_N_O,
    output logic            CHAN_FOURTH_SELECT_N_O,
    output logic [2:0]      ADDR_O,
    input  wire logic [7:0] DATA_I,
    output logic [7:0]      DATA_O,
    output logic            DATA_OE_N_O
);
    // ======================================================
    // state
    typedef enum logic [3:0] {
        S_IDLE   = 4'b0001,
        S_SETUP  = 4'b0010,
        S_STROBE = 4'b0100,
        S_DONE   = 4'b1000
    } state_t;

    state_t     state, next_state;
    logic [3:0] cnt, next_cnt;
    req_t       cur, next_cur;
    logic       style, next_style;
    logic [7:0] rdata, next_rdata;
    logic       rsp, next_rsp;
    pins_t      pins;
    logic       pin_style;

    // style latched per transfer so pins never change style mid-access
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_cur   = cur;
        next_style = style;
        next_rdata = rdata;
        next_rsp   = 1'b0;
        case (state)
            S_IDLE: begin
                if (REQ_VALID_I) begin
                    next_cur   = REQ_I;
                    next_style = STYLE_I;
                    next_cnt   = CNT_W0;
                    next_state = S_SETUP;
                end
            end
            S_SETUP: begin
                next_cnt = cnt + 4'h1;
                if (cnt == 4'(SETUP_CYC - 1)) begin
                    next_cnt   = CNT_W0;
                    next_state = S_STROBE;
                end
            end
            S_STROBE: begin
                next_cnt = cnt + 4'h1;
                if (cnt == 4'(STROBE_CYC - 1)) begin
                    // sample on the last low cycle, i.e. at the rising strobe edge
                    if (!cur.write) begin
                        next_rdata = DATA_I;
                        next_rsp   = 1'b1;
                    end
                    next_state = S_DONE;
                end
            end
            S_DONE: begin
                // one idle cycle with strobes high for hold and bus turnaround
                next_state = S_IDLE;
            end
            default: next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state <= S_IDLE;
            cnt   <= CNT_W0;
            cur   <= '0;
            style <= STYLE_STROBE;
            rdata <= 8'h00;
            rsp   <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            cur   <= next_cur;
            style <= next_style;
            rdata <= next_rdata;
            rsp   <= next_rsp;
        end
    end

    // ======================================================
    // pin drive
    // idle pins follow the mode pin, so the device never sees one style's pins under the other mode
    assign pin_style = (state == S_IDLE) ? STYLE_I : style;

    qbus_pin_map u_map (
        .style_i                  (pin_style),
        .active_i                 (state == S_SETUP || state == S_STROBE || state == S_DONE),
        .strobe_i                 (state == S_STROBE),
        .write_i                  (cur.write),
        .chan_i                   (cur.chan),
        .addr_i                   (cur.addr),
        .active_echo_o            (),
        .pins_o                   (pins)
    );

    // outputs
    assign REQ_READY_O            = (state == S_IDLE);
    assign RSP_VALID_O            = rsp;
    assign RSP_DATA_O             = rdata;
    assign MODE_SELECT_O          = pin_style;
    assign READ_STROBE_N_O        = pins.read_strobe_n;
    assign WRITE_STROBE_N_O       = pins.write_strobe_n;
    assign CHAN_FIRST_SELECT_N_O  = pins.select_n[0];
    assign CHAN_SECOND_SELECT_N_O = pins.select_n[1];
    assign CHAN_THIRD_SELECT_N_O  = pins.select_n[2];
    assign CHAN_FOURTH_SELECT_N_O = pins.select_n[3];
    assign ADDR_O                 = pins.addr;
    assign DATA_O                 = cur.data;
    // drive data only through a write access, released on idle
    assign DATA_OE_N_O = ~(cur.write && (state == S_SETUP || state == S_STROBE || state == S_DONE));

    // ======================================================
    // assertions
    property p_no_drive_on_read;
        @(posedge REF_CLK_I) disable iff (!RST_N_I) (!READ_STROBE_N_O) |-> DATA_OE_N_O;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("data driven during read");

    property p_rd_strobe_len;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            (style == STYLE_STROBE && $fell(READ_STROBE_N_O)) |-> !READ_STROBE_N_O [*5] ##1 READ_STROBE_N_O;
    endproperty
    a_rd_strobe_len: assert property (p_rd_strobe_len) else $error("read strobe width wrong");

    property p_capture;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            (style == STYLE_STROBE && $rose(READ_STROBE_N_O)) |-> RSP_VALID_O && RSP_DATA_O == $past(DATA_I);
    endproperty
    a_capture: assert property (p_capture) else $error("read byte not captured at rise");

    property p_wr_strobe;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            (style == STYLE_STROBE && !WRITE_STROBE_N_O) |-> !DATA_OE_N_O && READ_STROBE_N_O;
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe without data");

    property p_wr_hold;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            (style == STYLE_STROBE && $rose(WRITE_STROBE_N_O)) |-> !DATA_OE_N_O;
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("data released at write rise");

    property p_single_ties;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            (state != S_IDLE && style == STYLE_SINGLE) |-> READ_STROBE_N_O && CHAN_FOURTH_SELECT_N_O;
    endproperty
    a_single_ties: assert property (p_single_ties) else $error("unused pins not high");

    property p_single_dir;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            (state == S_STROBE && style == STYLE_SINGLE) |-> WRITE_STROBE_N_O == !cur.write && !CHAN_FIRST_SELECT_N_O;
    endproperty
    a_single_dir: assert property (p_single_dir) else $error("direction or select wrong");

    property p_single_chan;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            (state == S_STROBE && style == STYLE_SINGLE) |->
            {CHAN_THIRD_SELECT_N_O, CHAN_SECOND_SELECT_N_O} == cur.chan;
    endproperty
    a_single_chan: assert property (p_single_chan) else $error("channel bits wrong");

    property p_one_select;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            (state == S_STROBE && style == STYLE_STROBE) |-> $countones(~pins.select_n) == 1;
    endproperty
    a_one_select: assert property (p_one_select) else $error("not exactly one select");

    property p_idle_quiet;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            (state == S_IDLE) |-> DATA_OE_N_O && READ_STROBE_N_O && WRITE_STROBE_N_O && CHAN_FIRST_SELECT_N_O;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("pins not quiet in idle");

    property p_wr_strobe_len;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            (style == STYLE_STROBE && $fell(WRITE_STROBE_N_O)) |-> !WRITE_STROBE_N_O [*5] ##1 WRITE_STROBE_N_O;
    endproperty
    a_wr_strobe_len: assert property (p_wr_strobe_len) else $error("write strobe width wrong");

    property p_rsp_pulse;
        @(posedge REF_CLK_I) disable iff (!RST_N_I)
            RSP_VALID_O |-> (state == S_DONE && !cur.write) ##1 (!RSP_VALID_O);
    endproperty
    a_rsp_pulse: assert property (p_rsp_pulse) else $error("response pulse wrong");

    c_read:   cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I) $rose(RSP_VALID_O));
    c_write:  cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I) $rose(WRITE_STROBE_N_O) && style);
    c_single: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I) state == S_STROBE && !style);
    c_single_write: cover property (@(posedge REF_CLK_I) disable iff (!RST_N_I) state == S_STROBE && !style && cur.write);
endmodule : qbus_host
`default_nettype wire

/* File: qbus_pin_map.sv */
// maps a channel/direction/phase onto the device pins for either bus style
// assumes the caller holds its inputs stable through a transfer
`default_nettype none
module qbus_pin_map
    import qbus_pkg::*;
(
    input  wire logic       style_i,
    input  wire logic       active_i,
    input  wire logic       strobe_i,
    input  wire logic       write_i,
    input  wire logic [1:0] chan_i,
    input  wire logic [2:0] addr_i,
    output logic            active_echo_o,
    output pins_t           pins_o
);
    assign active_echo_o = active_i;
    // ======================================================
    // pin mapping
    always_comb begin
        pins_o = '{read_strobe_n: 1'b1, write_strobe_n: 1'b1, select_n: SEL_NONE, addr: addr_i};
        if (style_i == STYLE_STROBE) begin
            if (active_i) begin
                pins_o.select_n[chan_i] = 1'b0;
            end
            pins_o.read_strobe_n  = ~(strobe_i & ~write_i);
            pins_o.write_strobe_n = ~(strobe_i & write_i);
        end else begin
            // read strobe and fourth select tied high in this style
            pins_o.read_strobe_n  = 1'b1;
            pins_o.select_n[3]    = 1'b1;
            // direction rests at read outside an access, so a later style switch sees no stray edge
            pins_o.write_strobe_n = (active_i && write_i) ? DIR_WRITE : DIR_READ;
            pins_o.select_n[0]    = ~strobe_i;
            pins_o.select_n[1]    = chan_i[0];
            pins_o.select_n[2]    = chan_i[1];
        end
    end
endmodule : qbus_pin_map
`default_nettype wire

/* File: qbus_pkg.sv */
// package for the host-side parallel bus master of a four-channel uart
// assumes a single 100 MHz clock and synchronous active-low reset
`default_nettype none
package qbus_pkg;
    // ======================================================
    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int STROBE_LOW_NS  = 50;   // strobe low time, chosen
    localparam int STROBE_CYC     = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETUP_NS       = 20;   // address/select setup before strobe
    localparam int SETUP_CYC      = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CNT_W0 = 4'h0;
    // ======================================================
    // bus styles and pin levels
    localparam logic STYLE_STROBE = 1'b1;  // separate read/write strobes, one select per channel
    localparam logic STYLE_SINGLE = 1'b0;  // one select with read/write line
    localparam logic DIR_READ     = 1'b1;
    localparam logic DIR_WRITE    = 1'b0;
    localparam logic [3:0] SEL_NONE = 4'hf;
    // ======================================================
    // request carried from the user side
    typedef struct packed {
        logic       write;
        logic [1:0] chan;
        logic [2:0] addr;
        logic [7:0] data;
    } req_t;
    // pin bundle driven toward the device
    typedef struct packed {
        logic       read_strobe_n;
        logic       write_strobe_n;
        logic [3:0] select_n;      // first..fourth select pins, bit 0 first
        logic [2:0] addr;
    } pins_t;
endpackage : qbus_pkg
`default_nettype wire

/* File: quad_uart_dev_model.sv */
// device model: register port of a four-channel uart, 8 registers per channel
// assumes the host changes pins just after a rising clock edge
`default_nettype none
module quad_uart_dev_model (
    input  wire logic       clk_i,
    input  wire logic       mode_i,
    input  wire logic       rd_n_i,
    input  wire logic       wr_n_i,
    input  wire logic [3:0] sel_n_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] bus_i,
    output logic [7:0]      drv_o,
    output logic            drv_en_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // register array and write capture
    logic [7:0] regs [4][8] = '{default: 8'h00};
    logic [7:0] last = 8'h00;
    logic [7:0] wdat;
    logic [2:0] waddr;
    logic [1:0] ch;
    logic [1:0] wch;
    logic       hit;
    logic       rd;
    logic       wr;
    logic       wr_q = 1'b0;
    // pin meaning follows the mode pin
    always_comb begin
        if (mode_i) begin
            hit = $onehot(~sel_n_i);
            ch = {~sel_n_i[3] | ~sel_n_i[2], ~sel_n_i[3] | ~sel_n_i[1]};
            rd = !rd_n_i;
            wr = !wr_n_i;
        end else begin
            hit = !sel_n_i[0];
            ch = sel_n_i[2:1];
            rd = wr_n_i;
            wr = !wr_n_i;
        end
        drv_en_o = hit & rd;
        // a released bus shows the inverse of the last byte, never a stale match
        drv_o = drv_en_o ? regs[ch][addr_i] : ~last;
    end
    // byte lands when the write strobe or select goes away
    always @(posedge clk_i) begin
        wr_q <= hit & wr;
        if (hit & wr) begin
            wch <= ch;
            waddr <= addr_i;
            wdat <= bus_i;
        end
        if (wr_q && !(hit & wr))
            regs[wch][waddr] <= wdat;
        if (drv_en_o)
            last <= drv_o;
    end
endmodule : quad_uart_dev_model
`default_nettype wire

/* File: quad_uart_host_bus_port_bench.sv */
// self-checking bench: host bus master against the device model
// assumes qbus_pkg, qbus_host and quad_uart_dev_model are compiled first
`default_nettype none
module quad_uart_host_bus_port_bench import qbus_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ====================
    // signals
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       style = STYLE_STROBE;
    logic       req_valid = 1'b0;
    req_t       req = '0;
    logic       ready, rsp_valid, mode, rd_n, wr_n, sel0, sel1, sel2, sel3, oe_n, dev_en;
    logic [7:0] rsp_data, hdata, dev_drv, bus;
    logic [2:0] addr;
    logic [7:0] shadow [4][8] = '{default: 8'h00};
    int         err_total = 0;
    int         checks_done = 0;
    always #5 clk = ~clk;
    // wire level: host wins only while its enable is low
    assign bus = !oe_n ? hdata : dev_drv;
    qbus_host dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n), .STYLE_I(style), .REQ_VALID_I(req_valid),
        .REQ_READY_O(ready), .REQ_I(req), .RSP_VALID_O(rsp_valid), .RSP_DATA_O(rsp_data),
        .MODE_SELECT_O(mode), .READ_STROBE_N_O(rd_n), .WRITE_STROBE_N_O(wr_n),
        .CHAN_FIRST_SELECT_N_O(sel0), .CHAN_SECOND_SELECT_N_O(sel1), .CHAN_THIRD_SELECT_N_O(sel2),
        .CHAN_FOURTH_SELECT_N_O(sel3), .ADDR_O(addr), .DATA_I(bus), .DATA_O(hdata), .DATA_OE_N_O(oe_n));
    quad_uart_dev_model dev_u (.clk_i(clk), .mode_i(mode), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .sel_n_i({sel3, sel2, sel1, sel0}), .addr_i(addr), .bus_i(bus), .drv_o(dev_drv), .drv_en_o(dev_en));
    // ====================
    // reporting
    task automatic fail(input string m);
        $display("unexpected at %0t: %s", $time, m);
        err_total++;
    endtask : fail
    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    // two drivers on the data bus at once
    always @(negedge clk) begin
        if (!oe_n && dev_en) fail("bus contention");
    end
    // ====================
    // scenarios
    task automatic do_reset(input int n);
        rst_n = 1'b0;
        repeat (n) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        checks_done++;
        if ({rd_n, wr_n, sel3, sel2, sel1, sel0, oe_n, rsp_valid, ready} !== 9'h1fd) fail("not idle");
    endtask : do_reset
    // one transfer, entered at a falling edge; leaves at the earliest next take
    task automatic xfer(input logic st, input logic w, input logic [1:0] ch, input logic [2:0] a,
                        input logic [7:0] d);
        int lows;
        lows = 0;
        style = st;
        req = '{w, ch, a, d};
        req_valid = 1'b1;
        checks_done += 2;
        // ready is looked at off the edge that moves it, never in that edge's time step
        if (ready !== 1'b1) fail("not ready for request");
        @(negedge clk);
        req_valid = 1'b0;
        if (ready !== 1'b0) fail("request not taken");
        for (int n = 1; n <= 8; n++) begin
            checks_done += 6;
            if (mode !== st) fail("mode pin");
            if (st == STYLE_SINGLE && {rd_n, sel3} !== 2'b11) fail("unused pins");
            if (st == STYLE_SINGLE && !sel0 && ({sel2, sel1} !== ch || wr_n !== !w)) fail("chan or dir");
            if (st == STYLE_STROBE && {sel3, sel2, sel1, sel0} !== ~(4'h1 << ch)) fail("select");
            if (st == STYLE_STROBE && (w ? rd_n : wr_n) !== 1'b1) fail("wrong strobe");
            if (oe_n !== !w || (w && hdata !== d)) fail("data drive");
            if (rsp_valid !== (!w && n == 8)) fail("response timing");
            if (!w && n == 8 && rsp_data !== shadow[ch][a]) fail("read data");
            if ((st == STYLE_STROBE ? (w ? wr_n : rd_n) : sel0) === 1'b0) lows++;
            @(negedge clk);
        end
        if (w) shadow[ch][a] = d;
        checks_done += 3;
        if (lows != STROBE_CYC) fail("strobe length");
        if (w && dev_u.regs[ch][a] !== d) fail("byte not stored");
        if (ready !== 1'b1) fail("not ready again");
    endtask : xfer
    // ====================
    // main sequence and watchdog
    initial begin
        do_reset(20);
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 8; i++) xfer(s[0], 1'b1, i[1:0], i[2:0], 8'(8'h5a ^ (i * 37 + s)));
            // read back the very bytes just written, so a wrong channel or register shows
            for (int i = 0; i < 8; i++) xfer(s[0], 1'b0, i[1:0], i[2:0], 8'h00);
        end
        // abort a write in its setup phase, then read the untouched byte
        req = '{1'b1, 2'd2, 3'd5, 8'hc3};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        do_reset(2);
        xfer(STYLE_STROBE, 1'b0, 2'd2, 3'd5, 8'h00);
        conclude();
    end
    initial begin
        #20000;
        fail("watchdog expired");
        conclude();
    end
endmodule : quad_uart_host_bus_port_bench
`default_nettype wire
